/* core/gci_handshake.sv */
`timescale 1ns/1ps
`default_nettype none

// parameter load handshake: 0x0001 loads, 0x0000 finishes
module gci_handshake (
    input  wire logic   mclk,
    input  wire logic   rst_b,
    gci_hs_if.hs        hs
);

    typedef enum logic {HS_IDLE, HS_ACK} gci_hs_state_t;

    gci_hs_state_t       state_q, state_d;      // handshake phase
    gci_pkg::gci_param_t act_q, act_d;          // accepted parameter set
    logic                ok_q, ok_d;            // transfer_ok_flag

    ////////////////////////////////////////////////////////////////////////////
    // next state: other command values, including illegal multi-bit words,
    // leave the handshake alone so the old set stays in force
    always_comb begin
        state_d = state_q;
        act_d   = act_q;
        ok_d    = ok_q;
        unique case (state_q)
            HS_IDLE: begin
                if (hs.command_word == gci_pkg::CW_LOAD_PARAMS) begin
                    // adopt live data or a stored recipe selection
                    act_d = hs.image_params;
                    act_d.use_stored_recipe =
                        (hs.image_params.recipe_number != gci_pkg::RECIPE_LIVE);
                    ok_d    = 1'b1;
                    state_d = HS_ACK;
                end
            end
            HS_ACK: begin
                // wait for the zero word, then drop the flag
                if (hs.command_word == gci_pkg::CW_IDLE) begin
                    ok_d    = 1'b0;
                    state_d = HS_IDLE;
                end
            end
        endcase
    end

    // registers; the active set only changes on an accepted load
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q <= HS_IDLE;
            act_q   <= '0;
            ok_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            act_q   <= act_d;
            ok_q    <= ok_d;
        end
    end

    assign hs.active_params    = act_q;
    assign hs.transfer_ok_flag = ok_q;

endmodule

`default_nettype wire

/* core/gci_hs_if.sv */
`timescale 1ns/1ps
`default_nettype none

// carries the latched output image to the handshake unit and its answer back
interface gci_hs_if;
    logic [15:0]         command_word;          // latched command word
    gci_pkg::gci_param_t image_params;          // latched parameter fields
    gci_pkg::gci_param_t active_params;         // accepted parameter set
    logic                transfer_ok_flag;      // load accepted, awaiting zero word

    modport hs  (input command_word, input image_params,
                 output active_params, output transfer_ok_flag);
    modport top (output command_word, output image_params,
                 input active_params, input transfer_ok_flag);
endinterface

`default_nettype wire

/* core/gci_pkg.sv */
`default_nettype none

package gci_pkg;

    // clock rate, used to turn milliseconds into cycles
    localparam int unsigned CLK_KHZ        = 100000;

    // serial exchange cycle of the process image, in ms
    localparam int unsigned CYCLE_MS       = 5;
    localparam int unsigned CYCLE_CYC      = CYCLE_MS * CLK_KHZ;

    // delay from power-up until motion commands are accepted, in ms
    localparam int unsigned STARTUP_MS     = 5;
    localparam int unsigned STARTUP_CYC    = STARTUP_MS * CLK_KHZ;

    // output image (master to device), 64 bits, first field highest
    localparam int unsigned PO_W           = 64;
    localparam int unsigned PO_CMD_LSB     = 48;
    localparam int unsigned PO_MODE_LSB    = 40;
    localparam int unsigned PO_RECIPE_LSB  = 32;
    localparam int unsigned PO_TEACH_LSB   = 16;
    localparam int unsigned PO_FORCE_LSB   = 8;
    localparam int unsigned PO_WIN_LSB     = 0;

    // input image (device to master), 48 bits, first field highest
    localparam int unsigned PI_W           = 48;
    localparam int unsigned PI_FLAGS_LSB   = 32;
    localparam int unsigned PI_FAULT_LSB   = 16;
    localparam int unsigned PI_POS_LSB     = 0;

    // state_flags bit positions
    localparam int unsigned SF_CTRL_ACTIVE = 6;
    localparam int unsigned SF_XFER_OK     = 12;

    // command_word values
    localparam logic [15:0] CW_IDLE        = 16'h0000;
    localparam logic [15:0] CW_LOAD_PARAMS = 16'h0001;

    // recipe number that selects the transmitted process data
    localparam logic [7:0]  RECIPE_LIVE    = 8'h00;
    localparam logic [7:0]  RECIPE_MAX     = 8'h20;

    // reset values
    localparam logic [15:0] FLAGS_RST      = 16'h0000;

    // parameter set held by the device
    typedef struct packed {
        logic [7:0]  travel_profile_select;
        logic [7:0]  recipe_number;
        logic [15:0] taught_part_position;
        logic [7:0]  clamp_force_setting;
        logic [7:0]  position_window;
        logic        use_stored_recipe;
    } gci_param_t;

endpackage

`default_nettype wire

/* core/gci_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - active direction input starts matching jaw travel
// - motion continues until gripping finishes
// - sourcing control makes low level active
// - ready lamp, commands accepted after startup
// - lost workpiece: keep driving to end
// - output image: command, mode, recipe, teach, force, window
// - input image: flags, fault code, position
// - flags bit 6 shows controller active
// - process images exchanged every 5 ms
// - device sets transfer-ok after accepting load
// - transfer-ok cleared once command returns zero
// - load adopts live data or stored recipe
module gci_top #(
    parameter int unsigned CYCLE_CYC   = gci_pkg::CYCLE_CYC,   // image exchange period
    parameter int unsigned STARTUP_CYC = gci_pkg::STARTUP_CYC  // power-up hold-off
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    input  wire logic                   dir_inward_pin,
    input  wire logic                   dir_outward_pin,
    input  wire logic                   sourcing_pin,
    input  wire logic                   motion_done,
    input  wire logic                   workpiece_lost,
    input  wire logic                   po_valid,
    input  wire logic [gci_pkg::PO_W-1:0] po_image,
    input  wire logic [15:0]            fault_code,
    input  wire logic [15:0]            jaw_position_now,
    output logic                        move_inward,
    output logic                        move_outward,
    output logic                        ready_led,
    output logic                        image_tick,
    output logic [gci_pkg::PI_W-1:0]    pi_image,
    output gci_pkg::gci_param_t         active_params
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks: the period counter needs at least two cycles, the startup counter one
    if (CYCLE_CYC < 2) begin : g_bad_cycle
        $error("image period must be at least two clock cycles");
    end
    if (STARTUP_CYC < 1) begin : g_bad_start
        $error("startup hold-off must be at least one clock cycle");
    end

    localparam int unsigned CYC_W = $clog2(CYCLE_CYC);
    localparam int unsigned STW   = $clog2(STARTUP_CYC + 1);
    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CYCLE_CYC - 1);
    localparam logic [STW-1:0]   ST_LAST  = STW'(STARTUP_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: pins are asynchronous to mclk
    logic [2:0] sync1_q, sync1_d;      // first stage, read only by the second
    logic [2:0] sync2_q, sync2_d;      // second stage, safe to use

    always_comb begin
        sync1_d = {sourcing_pin, dir_outward_pin, dir_inward_pin};
        sync2_d = sync1_q;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // polarity: sourcing control means a low level commands motion
    logic want_in;                     // inward command seen at active level
    logic want_out;                    // outward command seen at active level
    always_comb begin
        want_in  = sync2_q[0] ^ sync2_q[2];
        want_out = sync2_q[1] ^ sync2_q[2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // startup hold-off and ready lamp
    logic [STW-1:0] start_cnt_q, start_cnt_d;  // cycles since reset release
    logic           ready_q, ready_d;          // device can operate

    always_comb begin
        start_cnt_d = start_cnt_q;
        ready_d     = ready_q;
        if (!ready_q) begin
            if (start_cnt_q == ST_LAST) begin
                ready_d = 1'b1;
            end else begin
                start_cnt_d = start_cnt_q + STW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            start_cnt_q <= '0;
            ready_q     <= 1'b0;
        end else begin
            start_cnt_q <= start_cnt_d;
            ready_q     <= ready_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // discrete motion sequencer
    typedef enum logic [1:0] {MV_IDLE, MV_IN, MV_OUT, MV_RELEASE} gci_mv_state_t;

    gci_mv_state_t mv_q, mv_d;         // motion phase
    logic          rel_in_q, rel_in_d; // which input must be released

    always_comb begin
        mv_d     = mv_q;
        rel_in_d = rel_in_q;
        unique case (mv_q)
            MV_IDLE: begin
                // one input alone starts travel; both at once start nothing
                if (ready_q && want_in && !want_out) begin
                    mv_d = MV_IN;
                end else if (ready_q && want_out && !want_in) begin
                    mv_d = MV_OUT;
                end
            end
            MV_IN, MV_OUT: begin
                // the input level no longer matters once travel has begun;
                // a lost workpiece does not stop travel, only the end does
                if (motion_done) begin
                    rel_in_d = (mv_q == MV_IN);
                    mv_d     = MV_RELEASE;
                end
            end
            MV_RELEASE: begin
                // a held command must drop before a new start, so a level
                // left high cannot retrigger the same stroke
                if (rel_in_q ? !want_in : !want_out) begin
                    mv_d = MV_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mv_q     <= MV_IDLE;
            rel_in_q <= 1'b0;
        end else begin
            mv_q     <= mv_d;
            rel_in_q <= rel_in_d;
        end
    end

    // drive requests follow the phase; workpiece_lost is deliberately ignored
    logic lost_unused;                 // kept only for visibility of the input
    always_comb begin
        lost_unused  = workpiece_lost;
        move_inward  = (mv_q == MV_IN);
        move_outward = (mv_q == MV_OUT);
    end

    ////////////////////////////////////////////////////////////////////////////
    // output image latch: the field order is fixed by the image layout
    logic [gci_pkg::PO_W-1:0] po_q, po_d;   // last received output image

    always_comb begin
        po_d = po_valid ? po_image : po_q;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            po_q <= '0;
        end else begin
            po_q <= po_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // parameter load handshake
    gci_hs_if hs_bus ();

    always_comb begin
        hs_bus.command_word = po_q[gci_pkg::PO_CMD_LSB +: 16];
        hs_bus.image_params.travel_profile_select =
            po_q[gci_pkg::PO_MODE_LSB +: 8];
        hs_bus.image_params.recipe_number =
            po_q[gci_pkg::PO_RECIPE_LSB +: 8];
        hs_bus.image_params.taught_part_position =
            po_q[gci_pkg::PO_TEACH_LSB +: 16];
        hs_bus.image_params.clamp_force_setting =
            po_q[gci_pkg::PO_FORCE_LSB +: 8];
        hs_bus.image_params.position_window =
            po_q[gci_pkg::PO_WIN_LSB +: 8];
        hs_bus.image_params.use_stored_recipe = 1'b0;
    end

    // image fields reach the motion side only through an accepted load
    gci_handshake u_hs (
        .mclk  (mclk),
        .rst_b (rst_b),
        .hs    (hs_bus.hs)
    );

    assign active_params = hs_bus.active_params;

    ////////////////////////////////////////////////////////////////////////////
    // exchange period timer and input image
    logic [CYC_W-1:0]         cyc_q, cyc_d;     // position in the period
    logic                     tick_q, tick_d;   // one-cycle period strobe
    logic [gci_pkg::PI_W-1:0] pi_q, pi_d;       // input image held for the master
    logic [15:0]              flags;            // state_flags now

    always_comb begin
        flags = gci_pkg::FLAGS_RST;
        flags[gci_pkg::SF_CTRL_ACTIVE] = ready_q;
        flags[gci_pkg::SF_XFER_OK]     = hs_bus.transfer_ok_flag;
        tick_d = 1'b0;
        pi_d   = pi_q;
        if (cyc_q == CYC_LAST) begin
            cyc_d  = '0;
            tick_d = 1'b1;
            // snapshot once per period so all fields belong together
            pi_d = {flags, fault_code, jaw_position_now};
        end else begin
            cyc_d = cyc_q + CYC_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cyc_q  <= '0;
            tick_q <= 1'b0;
            pi_q   <= '0;
        end else begin
            cyc_q  <= cyc_d;
            tick_q <= tick_d;
            pi_q   <= pi_d;
        end
    end

    assign image_tick = tick_q;
    assign pi_image   = pi_q;
    assign ready_led  = ready_q;

endmodule

`default_nettype wire

/* testbench/gci_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

// serial link master: sends output images and runs the parameter load
module gci_master_model (
    input  wire logic        mclk,
    input  wire logic [47:0] pi_image,
    output logic             po_valid,
    output logic [63:0]      po_image
);
    localparam int unsigned XOK = 44;  // transfer-ok within the input image

    initial begin
        po_valid = 1'b0;
        po_image = 64'h0;
    end

    // one image, first field highest; afterwards the word is scrambled so
    // a stale value cannot pass for a fresh one
    task automatic send(input logic [15:0] cw, input logic [7:0] rec);
        @(posedge mclk);
        po_valid <= 1'b1;
        po_image <= {cw, 8'h3c, rec, 16'h05dc, 8'h40, 8'h96};
        @(posedge mclk);
        po_valid <= 1'b0;
        po_image <= ~po_image;
    endtask

    // full load: start word, wait ok, zero word, wait ok cleared
    task automatic load(input logic [7:0] rec, output logic ok);
        int n;
        send(gci_pkg::CW_LOAD_PARAMS, rec);
        for (n = 0; n < 100 && pi_image[XOK] !== 1'b1; n++) @(posedge mclk);
        ok = (n < 100);
        send(gci_pkg::CW_IDLE, rec);
        for (n = 0; n < 100 && pi_image[XOK] !== 1'b0; n++) @(posedge mclk);
        ok = ok && (n < 100);
    endtask
endmodule

`default_nettype wire

/* testbench/gci_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// watches the gripper command front end at its ports only
module gci_top_properties #(
    parameter int unsigned CYCLE_CYC   = 20,
    parameter int unsigned STARTUP_CYC = 10
) (
    input wire logic                 mclk,
    input wire logic                 rst_b,
    input wire logic                 dir_inward_pin,
    input wire logic                 dir_outward_pin,
    input wire logic                 sourcing_pin,
    input wire logic                 motion_done,
    input wire logic                 workpiece_lost,
    input wire logic                 po_valid,
    input wire logic [63:0]          po_image,
    input wire logic [15:0]          fault_code,
    input wire logic [15:0]          jaw_position_now,
    input wire logic                 move_inward,
    input wire logic                 move_outward,
    input wire logic                 ready_led,
    input wire logic                 image_tick,
    input wire logic [47:0]          pi_image,
    input wire gci_pkg::gci_param_t  active_params
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // active levels after the polarity strap
    logic        act_in;
    logic        act_out;
    assign act_in  = dir_inward_pin ^ sourcing_pin;
    assign act_out = dir_outward_pin ^ sourcing_pin;

    ////////////////////////////////////////////////////////////////////////////////
    // cycles since the last image refresh; seen_q skips the first partial period
    logic [31:0] gap_q, gap_d;
    logic        seen_q, seen_d;
    always_comb begin
        gap_d  = image_tick ? 32'h0 : gap_q + 32'h1;
        seen_d = seen_q | image_tick;
    end
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b0;
        end else begin
            gap_q  <= gap_d;
            seen_q <= seen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // a stroke in progress, before and at the cycle the drive reports the end
    sequence s_in_busy;
        move_inward && !motion_done;
    endsequence
    sequence s_in_end;
        move_inward && motion_done;
    endsequence

    a_in_start: assert property ($rose(move_inward) |-> $past(act_in, 3) && !$past(act_out, 3))
        else $error("inward travel began without a lone active inward command");
    a_out_start: assert property ($rose(move_outward) |-> $past(act_out, 3) && !$past(act_in, 3))
        else $error("outward travel began without a lone active outward command");
    a_in_hold: assert property (s_in_busy |=> move_inward)
        else $error("inward travel dropped before the stroke ended");
    a_in_stop: assert property (s_in_end |=> !move_inward)
        else $error("inward travel kept going after the stroke ended");
    a_out_stop: assert property (move_outward && motion_done |=> !move_outward)
        else $error("outward travel kept going after the stroke ended");
    a_ready_gate: assert property (!ready_led |-> !move_inward && !move_outward)
        else $error("travel while not ready");
    a_one_dir: assert property (!(move_inward && move_outward))
        else $error("both directions driven at once");
    a_tick_period: assert property (image_tick && seen_q |-> gap_q == CYCLE_CYC - 1)
        else $error("image refresh period wrong");
    a_tick_late: assert property (seen_q |-> gap_q < CYCLE_CYC)
        else $error("image refresh missed");
    a_pi_steady: assert property (!image_tick |-> $stable(pi_image))
        else $error("input image changed between refreshes");
    a_image_fields: assert property (image_tick |->
        pi_image[31:0] == {$past(fault_code), $past(jaw_position_now)}
        && (pi_image[38] || !$past(ready_led, 2)))
        else $error("input image fields wrong");
    a_params_load: assert property ($changed(active_params) |-> $past(po_valid, 2)
        && active_params.recipe_number == $past(po_image[39:32], 2)
        && active_params.use_stored_recipe == (active_params.recipe_number != 8'h00))
        else $error("parameter set changed outside a load");
endmodule

`default_nettype wire

/* testbench/gci_top_test.sv */
`timescale 1ns/1ps
`default_nettype none

module gci_top_test;
    localparam int unsigned CYC   = 20;  // shortened image period
    localparam int unsigned SUC   = 10;  // shortened power-up hold-off
    localparam int unsigned PAUSE = 10;  // stands in for the long idle gap
    // direction case: strap, active in/out, expected travel in/out
    typedef struct packed {
        logic src, a_in, a_out, e_in, e_out;
    } gci_row_t;
    logic                mclk, rst_b, dir_in, dir_out, src, done, lost;
    logic                po_valid, mv_in, mv_out, rdy, tick, ok;
    logic [15:0]         fault, jaw;
    logic [63:0]         po_image;
    logic [47:0]         pi_image;
    gci_pkg::gci_param_t act, exp_p;
    int                  errors, cmp_count;
    // strap low for rows 0, 1 and 4, high for rows 2 and 3
    gci_row_t rows [5] = '{5'b01010, 5'b00101, 5'b11010, 5'b10101, 5'b01100};

    gci_top #(.CYCLE_CYC(CYC), .STARTUP_CYC(SUC)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .dir_inward_pin(dir_in), .dir_outward_pin(dir_out),
        .sourcing_pin(src), .motion_done(done), .workpiece_lost(lost), .po_valid(po_valid),
        .po_image(po_image), .fault_code(fault), .jaw_position_now(jaw), .move_inward(mv_in),
        .move_outward(mv_out), .ready_led(rdy), .image_tick(tick), .pi_image(pi_image),
        .active_params(act));
    gci_master_model mm_u (.mclk(mclk), .pi_image(pi_image), .po_valid(po_valid),
        .po_image(po_image));

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chkv(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: word got %h expected %h", $time, got, exp);
        end
    endtask
    // wait n edges, then let their updates settle
    task automatic tick_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic final_report;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // a hang counts as a mismatch and ends the run the ordinary way
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        final_report;
    end

    initial begin
        {rst_b, dir_in, dir_out, src, done, lost} = 6'h0;
        fault = 16'h00a5;
        jaw   = 16'h1234;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        tick_n(1);
        chkv({mv_in, mv_out, rdy, pi_image}, 64'h0);
        chkv(act, 64'h0);
        tick_n(6);
        chk1(rdy, 1'b0);
        tick_n(10);
        chk1(rdy, 1'b1);
        // direction table: start, survive a lost part, stop on done
        foreach (rows[i]) begin
            @(posedge mclk);
            src <= rows[i].src;
            dir_in <= rows[i].src;
            dir_out <= rows[i].src;
            tick_n(4);
            @(posedge mclk);
            dir_in <= rows[i].a_in ^ rows[i].src;
            dir_out <= rows[i].a_out ^ rows[i].src;
            tick_n(3);
            chkv({mv_in, mv_out}, {rows[i].e_in, rows[i].e_out});
            @(posedge mclk) lost <= 1'b1;
            tick_n(5);
            chkv({mv_in, mv_out}, {rows[i].e_in, rows[i].e_out});
            @(posedge mclk) begin
                lost <= 1'b0;
                done <= 1'b1;
            end
            tick_n(1);
            chkv({mv_in, mv_out}, 64'h0);
            @(posedge mclk) begin
                done <= 1'b0;
                dir_in <= rows[i].src;
                dir_out <= rows[i].src;
            end
            tick_n(PAUSE);
        end
        // parameter loads: live data, then a stored recipe
        for (int r = 0; r < 2; r++) begin
            mm_u.load(8'(r * 5), ok);
            chk1(ok, 1'b1);
            exp_p = '{8'h3c, 8'(r * 5), 16'h05dc, 8'h40, 8'h96, r == 1};
            chkv(act, exp_p);
        end
        // every other command bit and a two-bit word leave the set alone
        for (int b = 1; b < 16; b++) mm_u.send(16'h0001 << b, 8'h07);
        mm_u.send(16'h0003, 8'h07);
        tick_n(2 * CYC);
        chkv(act, exp_p);
        chk1(pi_image[44], 1'b0);
        for (int n = 0; n < CYC + 2 && tick !== 1'b1; n++) tick_n(1);
        chkv(pi_image, {16'h0040, 16'h00a5, 16'h1234});
        // restart with both inputs idle
        @(posedge mclk) rst_b <= 1'b0;
        tick_n(3);
        chkv({mv_in, mv_out, rdy, pi_image}, 64'h0);
        chkv(act, 64'h0);
        @(posedge mclk) rst_b <= 1'b1;
        tick_n(4);
        final_report;
    end
endmodule

bind gci_top gci_top_properties #(.CYCLE_CYC(CYCLE_CYC), .STARTUP_CYC(STARTUP_CYC)) chk_u (
    .mclk(mclk), .rst_b(rst_b), .dir_inward_pin(dir_inward_pin),
    .dir_outward_pin(dir_outward_pin), .sourcing_pin(sourcing_pin), .motion_done(motion_done),
    .workpiece_lost(workpiece_lost), .po_valid(po_valid), .po_image(po_image),
    .fault_code(fault_code), .jaw_position_now(jaw_position_now), .move_inward(move_inward),
    .move_outward(move_outward), .ready_led(ready_led), .image_tick(image_tick),
    .pi_image(pi_image), .active_params(active_params));

`default_nettype wire
